//--- hdc_asserts.sv
// hdc_asserts: checks on the link between the two ends
// assumes: placed in tb beside hdc_if, one clock domain
`timescale 1ns/10ps
module hdc_asserts (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        arst_n_in,
  // link signals
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic        irq_pin,
  input wire logic        dma_req_pin,
  input wire logic        dma_ack_n,
  input wire logic        dma_rd_strb,
  input wire logic        dma_wr_strb
);
  logic [15:0] hw_r;
  logic        rd_hw;
  logic        rd_dma;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  assign rd_hw  = cmd_valid && cmd_code == 8'h20;
  assign rd_dma = cmd_valid && cmd_code == 8'h21;
  // shadow of the hardware config register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) hw_r <= 16'h0028;
    else if (cmd_valid && cmd_code == 8'hA0) hw_r <= (cmd_wdata & 16'h1CA7) | 16'h0008;
  end
  chk_read_answer: assert property ((rd_hw || rd_dma) |=> rsp_valid)
    else $error("read code got no answer");
  chk_write_silent: assert property (cmd_valid && cmd_code[7] |=> !rsp_valid)
    else $error("write code answered");
  chk_width_field: assert property (rd_hw |=> rsp_data[4:3] == 2'b01)
    else $error("bus width field not 01");
  chk_ack_reserved: assert property (rd_hw |=> !rsp_data[8] && !rsp_data[6])
    else $error("reserved ack setting reads set");
  chk_hw_readback: assert property (rd_hw |=> rsp_data == hw_r)
    else $error("hardware config readback wrong");
  chk_dma_reserved: assert property (rd_dma |=> rsp_data[15:7] == 9'h000 && !rsp_data[3])
    else $error("dma config reserved bits set");
  chk_irq_master_off: assert property ($stable(hw_r) && !hw_r[0] |-> irq_pin == !hw_r[2])
    else $error("irq pin active while disabled");
  chk_irq_edge_pulse: assert property (hw_r[0] && hw_r[1] && $stable(hw_r) && irq_pin == hw_r[2]
    |=> irq_pin != hw_r[2])
    else $error("edge irq longer than one cycle");
  chk_ack_strobe: assert property (!dma_ack_n |-> dma_rd_strb != dma_wr_strb)
    else $error("ack without one strobe");
  chk_ack_single: assert property (!dma_ack_n |=> dma_ack_n)
    else $error("ack held two cycles");
  chk_req_stop: assert property (cmd_valid && cmd_code == 8'hA1 && !cmd_wdata[4]
    |-> ##[1:3] dma_req_pin == !hw_r[5])
    else $error("request kept after stop");
  cov_read: cover property (rd_hw ##1 rsp_valid);
  cov_beat_rd: cover property (!dma_ack_n && dma_rd_strb);
  cov_beat_wr: cover property (!dma_ack_n && dma_wr_strb);
  cov_irq_on: cover property (hw_r[0] && irq_pin == hw_r[2]);
endmodule

//--- hdc_ctl.sv
// hdc_ctl: processor and external dma controller end, driven over axi4-lite
// assumes: device end on the same clock behind hdc_if.dev_mp
`timescale 1ns/10ps
module hdc_ctl (
  // clock and reset
  input  wire logic                          clk_in,
  input  wire logic                          arst_n_in,
  // axi4-lite write
  input  wire logic [hdc_pkg::CTL_ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic                          s_axi_awvalid_in,
  output logic                               s_axi_awready_out,
  input  wire logic [31:0]                   s_axi_wdata_in,
  input  wire logic [3:0]                    s_axi_wstrb_in,
  input  wire logic                          s_axi_wvalid_in,
  output logic                               s_axi_wready_out,
  output logic [1:0]                         s_axi_bresp_out,
  output logic                               s_axi_bvalid_out,
  input  wire logic                          s_axi_bready_in,
  // axi4-lite read
  input  wire logic [hdc_pkg::CTL_ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic                          s_axi_arvalid_in,
  output logic                               s_axi_arready_out,
  output logic [31:0]                        s_axi_rdata_out,
  output logic [1:0]                         s_axi_rresp_out,
  output logic                               s_axi_rvalid_out,
  input  wire logic                          s_axi_rready_in,
  // link to device
  hdc_if.ctl_mp                              bus
);
  typedef struct packed {
    logic        aw_h;
    logic [7:0]  aw_a;
    logic        w_h;
    logic [31:0] w_d;
    logic [3:0]  w_s;
    logic        bv;
    logic [1:0]  br;
    logic        rv;
    logic [31:0] rd;
    logic [1:0]  rr;
    logic [31:0] cmd;
    logic        rsp_h;
    logic [15:0] rsp_d;
    logic [31:0] dctl;
    logic [15:0] ddat;
    logic [15:0] drd;
    logic [15:0] beats;
    logic        cmd_v;
    logic        ack_n;
    logic        rd_s;
    logic        wr_s;
    logic [15:0] dwd;
    logic        end_act;
    logic        phase;
  } hdc_ctl_state_t;

  localparam hdc_ctl_state_t ST_RESET = '{ack_n: 1'b1, default: '0};

  hdc_ctl_state_t s_r;
  hdc_ctl_state_t s_nxt;
  logic [31:0]    wval;
  logic [15:0]    beats_inc;
  logic           req_act;

  function automatic logic [31:0] hdc_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    s_nxt         = s_r;
    s_nxt.cmd_v   = 1'b0;
    s_nxt.ack_n   = 1'b1;
    s_nxt.rd_s    = 1'b0;
    s_nxt.wr_s    = 1'b0;
    s_nxt.end_act = 1'b0;
    wval          = 32'h0000_0000;
    beats_inc     = s_r.beats + 16'h0001;
    // axi write channels
    if (s_axi_awvalid_in && !s_r.aw_h) begin
      s_nxt.aw_h = 1'b1;
      s_nxt.aw_a = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !s_r.w_h) begin
      s_nxt.w_h = 1'b1;
      s_nxt.w_d = s_axi_wdata_in;
      s_nxt.w_s = s_axi_wstrb_in;
    end
    if (s_r.bv && s_axi_bready_in) begin
      s_nxt.bv = 1'b0;
    end
    // dma handshake as external controller
    req_act = (bus.dma_req_pin == s_r.dctl[hdc_pkg::DC_REQ_POL]);
    if (!s_r.dctl[hdc_pkg::DC_GO] || s_r.phase) begin
      s_nxt.phase = 1'b0;
    end else if (req_act) begin
      s_nxt.phase = 1'b1;
      s_nxt.ack_n = 1'b0;
      s_nxt.rd_s  = !s_r.dctl[hdc_pkg::DC_DIR];
      s_nxt.wr_s  = s_r.dctl[hdc_pkg::DC_DIR];
      s_nxt.dwd   = s_r.ddat;
      s_nxt.beats = beats_inc;
      if (!s_r.dctl[hdc_pkg::DC_DIR]) begin
        s_nxt.drd = bus.dma_rdata;
      end
      if (s_r.dctl[hdc_pkg::DC_EOT] && beats_inc == s_r.dctl[hdc_pkg::DC_END_LO +: 16]) begin
        s_nxt.end_act             = 1'b1;
        s_nxt.dctl[hdc_pkg::DC_GO] = 1'b0;
      end
    end
    // register write
    if (s_r.aw_h && s_r.w_h && !s_r.bv) begin
      s_nxt.aw_h = 1'b0;
      s_nxt.w_h  = 1'b0;
      s_nxt.bv   = 1'b1;
      s_nxt.br   = hdc_pkg::RESP_OKAY;
      case (s_r.aw_a)
        hdc_pkg::CTL_CMD: begin
          wval        = hdc_merge(s_r.cmd, s_r.w_d, s_r.w_s);
          s_nxt.cmd   = wval;
          s_nxt.cmd_v = 1'b1;
          s_nxt.rsp_h = 1'b0;
        end
        hdc_pkg::CTL_DMA: begin
          wval       = hdc_merge(s_r.dctl, s_r.w_d, s_r.w_s);
          s_nxt.dctl = wval;
          if (wval[hdc_pkg::DC_GO]) begin
            s_nxt.beats = 16'h0000;
          end
        end
        hdc_pkg::CTL_DDATA: begin
          wval       = hdc_merge({16'h0000, s_r.ddat}, s_r.w_d, s_r.w_s);
          s_nxt.ddat = wval[15:0];
        end
        hdc_pkg::CTL_STAT, hdc_pkg::CTL_RSP, hdc_pkg::CTL_BEATS: begin
        end
        default: begin
          s_nxt.br = hdc_pkg::RESP_SLVERR;
        end
      endcase
    end
    // device answer wins over the clear
    if (bus.rsp_valid) begin
      s_nxt.rsp_h = 1'b1;
      s_nxt.rsp_d = bus.rsp_data;
    end
    // register read
    if (s_r.rv && s_axi_rready_in) begin
      s_nxt.rv = 1'b0;
    end
    if (s_axi_arvalid_in && !s_r.rv) begin
      s_nxt.rv = 1'b1;
      s_nxt.rr = hdc_pkg::RESP_OKAY;
      case (s_axi_araddr_in)
        hdc_pkg::CTL_CMD:   s_nxt.rd = s_r.cmd;
        hdc_pkg::CTL_STAT:  s_nxt.rd = {28'h000_0000, bus.dma_req_pin, bus.irq_pin,
                                        s_r.dctl[hdc_pkg::DC_GO], s_r.rsp_h};
        hdc_pkg::CTL_RSP:   s_nxt.rd = {16'h0000, s_r.rsp_d};
        hdc_pkg::CTL_DMA:   s_nxt.rd = s_r.dctl;
        hdc_pkg::CTL_DDATA: s_nxt.rd = {16'h0000, s_r.drd};
        hdc_pkg::CTL_BEATS: s_nxt.rd = {16'h0000, s_r.beats};
        default: begin
          s_nxt.rd = 32'h0000_0000;
          s_nxt.rr = hdc_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_r <= ST_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // axi outputs
  assign s_axi_awready_out = !s_r.aw_h;
  assign s_axi_wready_out  = !s_r.w_h;
  assign s_axi_bvalid_out  = s_r.bv;
  assign s_axi_bresp_out   = s_r.br;
  assign s_axi_arready_out = !s_r.rv;
  assign s_axi_rvalid_out  = s_r.rv;
  assign s_axi_rdata_out   = s_r.rd;
  assign s_axi_rresp_out   = s_r.rr;

  // link outputs
  assign bus.cmd_valid    = s_r.cmd_v;
  assign bus.cmd_code     = s_r.cmd[7:0];
  assign bus.cmd_wdata    = s_r.cmd[31:16];
  assign bus.dma_ack_n    = s_r.ack_n;
  assign bus.dma_rd_strb  = s_r.rd_s;
  assign bus.dma_wr_strb  = s_r.wr_s;
  assign bus.dma_wdata    = s_r.dwd;
  assign bus.xfer_end_pin = s_r.end_act ~^ s_r.dctl[hdc_pkg::DC_END_POL];
endmodule

//--- hdc_dev.sv
// hdc_dev: host-side configuration registers, irq pin and dma request engine
// assumes: controller on the same clock drives hdc_if.ctl_mp; buffer memory on user side
`timescale 1ns/10ps
module hdc_dev (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // link to controller
  hdc_if.dev_mp            bus,
  // interrupt events
  input  wire logic [7:0]  event_pending_in,
  input  wire logic [7:0]  event_enable_in,
  // port and power
  input  wire logic        oc_digital_in,
  input  wire logic        oc_analog_in,
  input  wire logic        suspend_in,
  output logic             overcurrent_out,
  output logic             clock_stop_ok_out,
  output logic             port_pulldown_sel_out,
  // buffer memory
  input  wire logic [15:0] mem_rdata_in,
  output logic             mem_rd_out,
  output logic             mem_wr_out,
  output logic [15:0]      mem_wdata_out,
  output logic             list_buffer_sel_out,
  // transfer done
  output logic             all_eot_out
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REQ,
    ST_GAP
  } hdc_dma_st_t;

  typedef struct packed {
    hdc_dma_st_t st;
    logic [15:0] hw;
    logic [15:0] dma;
    logic [15:0] cnt;
    logic [15:0] done;
    logic [3:0]  beats;
    logic        rsp_v;
    logic [15:0] rsp_d;
    logic        irq_prev;
    logic        irq_pin;
    logic        req_pin;
    logic        mem_rd;
    logic        mem_wr;
    logic [15:0] mem_wd;
    logic [15:0] dma_rd;
    logic        eot;
    logic        oc;
    logic        stop_ok;
    logic [1:0]  oc_s1;
    logic [1:0]  oc_s2;
    logic [1:0]  oc_s3;
    logic [1:0]  oc_f;
  } hdc_dev_state_t;

  localparam hdc_dev_state_t ST_RESET = '{
    st:      ST_IDLE,
    hw:      hdc_pkg::HW_RESET,
    dma:     hdc_pkg::DMA_RESET,
    cnt:     hdc_pkg::CNT_RESET,
    irq_pin: 1'b1,
    default: '0
  };

  hdc_dev_state_t s_r;
  hdc_dev_state_t s_nxt;
  logic           end_act;
  logic           ack_act;
  logic           beat;
  logic           fin;
  logic           irq_lvl;
  logic           irq_out;
  logic [3:0]     burst;
  logic [15:0]    done_inc;

  always_comb begin
    s_nxt        = s_r;
    s_nxt.rsp_v  = 1'b0;
    s_nxt.mem_rd = 1'b0;
    s_nxt.mem_wr = 1'b0;
    s_nxt.eot    = 1'b0;
    s_nxt.dma_rd = mem_rdata_in;
    // processor bus commands
    if (bus.cmd_valid) begin
      case (bus.cmd_code)
        hdc_pkg::CMD_HW_RD: begin
          s_nxt.rsp_v = 1'b1;
          s_nxt.rsp_d = s_r.hw;
        end
        hdc_pkg::CMD_HW_WR: begin
          s_nxt.hw = (bus.cmd_wdata & hdc_pkg::HW_WMASK) | hdc_pkg::HW_FIXED;
        end
        hdc_pkg::CMD_DMA_RD: begin
          s_nxt.rsp_v = 1'b1;
          s_nxt.rsp_d = s_r.dma;
        end
        hdc_pkg::CMD_DMA_WR: begin
          s_nxt.dma = bus.cmd_wdata & hdc_pkg::DMA_WMASK;
        end
        hdc_pkg::CMD_CNT_RD: begin
          s_nxt.rsp_v = 1'b1;
          s_nxt.rsp_d = s_r.cnt;
        end
        hdc_pkg::CMD_CNT_WR: begin
          s_nxt.cnt = bus.cmd_wdata;
        end
        default: begin
        end
      endcase
    end
    // burst length lookup
    case (s_r.dma[hdc_pkg::DMA_BURST_LO +: 2])
      hdc_pkg::BURST_4: burst = hdc_pkg::BEATS_4;
      hdc_pkg::BURST_8: burst = hdc_pkg::BEATS_8;
      default:          burst = hdc_pkg::BEATS_1;
    endcase
    end_act  = (bus.xfer_end_pin == s_r.hw[hdc_pkg::HW_END_POL]);
    ack_act  = ~bus.dma_ack_n;
    beat     = (s_r.st == ST_REQ) && ack_act && (bus.dma_rd_strb || bus.dma_wr_strb);
    done_inc = s_r.done + hdc_pkg::BYTES_PER_BEAT;
    fin      = 1'b0;
    // dma request engine
    case (s_r.st)
      ST_IDLE: begin
        if (s_r.dma[hdc_pkg::DMA_RUN] &&
            (!s_r.dma[hdc_pkg::DMA_CNT_SEL] || s_r.cnt != 16'h0000)) begin
          s_nxt.st    = ST_REQ;
          s_nxt.beats = burst;
        end
      end
      ST_REQ: begin
        if (beat) begin
          s_nxt.done  = done_inc;
          s_nxt.beats = s_r.beats - 4'h1;
          if (s_r.dma[hdc_pkg::DMA_DIR]) begin
            s_nxt.mem_wr = 1'b1;
            s_nxt.mem_wd = bus.dma_wdata;
          end else begin
            s_nxt.mem_rd = 1'b1;
          end
          if (s_r.dma[hdc_pkg::DMA_CNT_SEL] && done_inc >= s_r.cnt) begin
            fin = 1'b1;
          end else if (s_r.beats == 4'h1) begin
            s_nxt.st = ST_GAP;
          end
        end
      end
      ST_GAP: begin
        s_nxt.st    = ST_REQ;
        s_nxt.beats = burst;
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    if (s_r.st != ST_IDLE && !s_r.dma[hdc_pkg::DMA_CNT_SEL] && end_act) begin
      fin = 1'b1;
    end
    if (fin) begin
      s_nxt.dma[hdc_pkg::DMA_RUN] = 1'b0;
      s_nxt.eot                   = 1'b1;
    end
    if (!s_nxt.dma[hdc_pkg::DMA_RUN]) begin
      s_nxt.st   = ST_IDLE;
      s_nxt.done = 16'h0000;
    end
    s_nxt.req_pin = (s_nxt.st == ST_REQ) ~^ s_nxt.hw[hdc_pkg::HW_REQ_POL];
    // interrupt pin
    irq_lvl = s_r.hw[hdc_pkg::HW_IRQ_EN] && |(event_pending_in & event_enable_in);
    irq_out = s_r.hw[hdc_pkg::HW_IRQ_TRIG] ? (irq_lvl && !s_r.irq_prev) : irq_lvl;
    s_nxt.irq_prev = irq_lvl;
    s_nxt.irq_pin  = irq_out ~^ s_r.hw[hdc_pkg::HW_IRQ_POL];
    // port and power
    // overcurrent pins: three flops, change taken once last two agree
    s_nxt.oc_s1   = {oc_analog_in, oc_digital_in};
    s_nxt.oc_s2   = s_r.oc_s1;
    s_nxt.oc_s3   = s_r.oc_s2;
    s_nxt.oc_f    = (s_r.oc_s2 & s_r.oc_s3) | (s_r.oc_f & (s_r.oc_s2 | s_r.oc_s3));
    s_nxt.oc      = s_r.hw[hdc_pkg::HW_OC_SEL] ? s_r.oc_f[1] : s_r.oc_f[0];
    s_nxt.stop_ok = suspend_in && !s_r.hw[hdc_pkg::HW_SUSP_KEEP];
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_r <= ST_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // link outputs
  assign bus.rsp_valid   = s_r.rsp_v;
  assign bus.rsp_data    = s_r.rsp_d;
  assign bus.irq_pin     = s_r.irq_pin;
  assign bus.dma_req_pin = s_r.req_pin;
  assign bus.dma_rdata   = s_r.dma_rd;

  // user outputs
  assign overcurrent_out       = s_r.oc;
  assign clock_stop_ok_out     = s_r.stop_ok;
  assign port_pulldown_sel_out = s_r.hw[hdc_pkg::HW_PULLDOWN];
  assign mem_rd_out            = s_r.mem_rd;
  assign mem_wr_out            = s_r.mem_wr;
  assign mem_wdata_out         = s_r.mem_wd;
  assign list_buffer_sel_out   = s_r.dma[hdc_pkg::DMA_LIST];
  assign all_eot_out           = s_r.eot;
endmodule

//--- hdc_if.sv
// hdc_if: processor bus, dma handshake and irq pin between the two ends
// assumes: both ends share one clock; the bench instantiates and joins
`timescale 1ns/10ps
interface hdc_if;
  // processor bus
  logic        cmd_valid;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  // pins
  logic        irq_pin;
  logic        dma_req_pin;
  logic        dma_ack_n;
  logic        dma_rd_strb;
  logic        dma_wr_strb;
  logic        xfer_end_pin;
  logic [15:0] dma_wdata;
  logic [15:0] dma_rdata;

  modport dev_mp (
    input  cmd_valid, cmd_code, cmd_wdata, dma_ack_n, dma_rd_strb, dma_wr_strb, xfer_end_pin, dma_wdata,
    output rsp_valid, rsp_data, irq_pin, dma_req_pin, dma_rdata
  );
  modport ctl_mp (
    output cmd_valid, cmd_code, cmd_wdata, dma_ack_n, dma_rd_strb, dma_wr_strb, xfer_end_pin, dma_wdata,
    input  rsp_valid, rsp_data, irq_pin, dma_req_pin, dma_rdata
  );
endinterface

//--- hdc_pkg.sv
// hdc_pkg: shared constants for the host dma / irq pin configuration ends
// assumes: both ends and the bench refer to names as hdc_pkg::name
package hdc_pkg;
  // processor bus command codes
  localparam logic [7:0] CMD_HW_RD   = 8'h20;
  localparam logic [7:0] CMD_HW_WR   = 8'hA0;
  localparam logic [7:0] CMD_DMA_RD  = 8'h21;
  localparam logic [7:0] CMD_DMA_WR  = 8'hA1;
  localparam logic [7:0] CMD_CNT_RD  = 8'h22;
  localparam logic [7:0] CMD_CNT_WR  = 8'hA2;
  // host_hardware_config fields
  localparam int HW_IRQ_EN    = 0;
  localparam int HW_IRQ_TRIG  = 1;
  localparam int HW_IRQ_POL   = 2;
  localparam int HW_REQ_POL   = 5;
  localparam int HW_END_POL   = 7;
  localparam int HW_OC_SEL    = 10;
  localparam int HW_SUSP_KEEP = 11;
  localparam int HW_PULLDOWN  = 12;
  localparam logic [15:0] HW_RESET = 16'h0028;
  localparam logic [15:0] HW_WMASK = 16'h1CA7;
  localparam logic [15:0] HW_FIXED = 16'h0008;
  // host_dma_config fields
  localparam int DMA_DIR      = 0;
  localparam int DMA_LIST     = 1;
  localparam int DMA_CNT_SEL  = 2;
  localparam int DMA_RUN      = 4;
  localparam int DMA_BURST_LO = 5;
  localparam logic [15:0] DMA_RESET = 16'h0000;
  localparam logic [15:0] DMA_WMASK = 16'h0077;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  // burst codes and beat counts
  localparam logic [1:0] BURST_1  = 2'h0;
  localparam logic [1:0] BURST_4  = 2'h1;
  localparam logic [1:0] BURST_8  = 2'h2;
  localparam logic [3:0] BEATS_1  = 4'h1;
  localparam logic [3:0] BEATS_4  = 4'h4;
  localparam logic [3:0] BEATS_8  = 4'h8;
  localparam logic [15:0] BYTES_PER_BEAT = 16'h0002;
  // controller register map
  localparam int          CTL_ADDR_W = 8;
  localparam logic [7:0]  CTL_CMD    = 8'h00;
  localparam logic [7:0]  CTL_STAT   = 8'h04;
  localparam logic [7:0]  CTL_RSP    = 8'h08;
  localparam logic [7:0]  CTL_DMA    = 8'h0C;
  localparam logic [7:0]  CTL_DDATA  = 8'h10;
  localparam logic [7:0]  CTL_BEATS  = 8'h14;
  localparam int DC_GO      = 0;
  localparam int DC_DIR     = 1;
  localparam int DC_EOT     = 2;
  localparam int DC_REQ_POL = 3;
  localparam int DC_END_POL = 4;
  localparam int DC_END_LO  = 16;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

//--- tb.sv
// tb: joins both ends, drives the controller over axi4-lite
// assumes: one 100 MHz clock; device user pins driven here
`timescale 1ns/10ps
module tb;
  logic        clk_in, arst_n_in;
  logic [7:0]  awaddr, araddr, pend, ena;
  logic [31:0] wdata, rdata, s;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  rresp, rr, br;
  logic        oc_dig, oc_ana, susp, oc, stop_ok, mem_rd, mem_wr, list_sel, eot, req_act, pdn;
  logic [15:0] mem_wd, last_wd, rd16;
  int          mismatches, check_count, cycles, run, run_max, beats, n_eot, hi;
  int          mx[3] = '{1, 4, 8};
  hdc_if intf();
  hdc_dev i_hdc_dev (.clk_in, .arst_n_in, .bus(intf.dev_mp), .event_pending_in(pend),
    .event_enable_in(ena), .oc_digital_in(oc_dig), .oc_analog_in(oc_ana), .suspend_in(susp),
    .overcurrent_out(oc), .clock_stop_ok_out(stop_ok), .port_pulldown_sel_out(pdn),
    .mem_rdata_in(16'h5A3C), .mem_rd_out(mem_rd), .mem_wr_out(mem_wr), .mem_wdata_out(mem_wd),
    .list_buffer_sel_out(list_sel), .all_eot_out(eot));
  hdc_ctl i_hdc_ctl (.clk_in, .arst_n_in, .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(br),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .bus(intf.ctl_mp));
  hdc_asserts i_hdc_asserts (.clk_in, .arst_n_in, .cmd_valid(intf.cmd_valid),
    .cmd_code(intf.cmd_code), .cmd_wdata(intf.cmd_wdata), .rsp_valid(intf.rsp_valid),
    .rsp_data(intf.rsp_data), .irq_pin(intf.irq_pin), .dma_req_pin(intf.dma_req_pin),
    .dma_ack_n(intf.dma_ack_n), .dma_rd_strb(intf.dma_rd_strb), .dma_wr_strb(intf.dma_wr_strb));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("[ERR] %0t run too long", $time);
      give_verdict();
    end
  end
  // beat and burst monitor, sampled mid-cycle
  always @(negedge clk_in) begin
    if (!intf.dma_ack_n && (intf.dma_rd_strb || intf.dma_wr_strb) && intf.dma_req_pin === req_act) run++;
    else if (intf.dma_req_pin !== req_act) run = 0;
    if (run > run_max) run_max = run;
    if (mem_rd === 1'b1 || mem_wr === 1'b1) beats++;
    if (mem_wr === 1'b1) last_wd = mem_wd;
    if (eot === 1'b1) n_eot++;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    b_t = 1'b0;
    @(posedge clk_in);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!b_t) begin
      @(negedge clk_in);
      aw_t = awvalid && awready;
      w_t  = wvalid && wready;
      b_t  = bvalid;
      @(posedge clk_in);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    r_t = 1'b0;
    @(posedge clk_in);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!r_t) begin
      @(negedge clk_in);
      ar_t = arvalid && arready;
      r_t  = rvalid;
      d    = rdata;
      r    = rresp;
      @(posedge clk_in);
      if (ar_t) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task automatic dev_cmd(input logic [7:0] code, input logic [15:0] wd);
    axi_write(hdc_pkg::CTL_CMD, {wd, 8'h00, code});
  endtask
  task automatic dev_read(input logic [7:0] code);
    dev_cmd(code, 16'h0000);
    s = 32'h0000_0000;
    while (s[0] !== 1'b1) axi_read(hdc_pkg::CTL_STAT, s, rr);
    axi_read(hdc_pkg::CTL_RSP, s, rr);
    rd16 = s[15:0];
  endtask
  task automatic run_dma(input logic [15:0] dcfg, input logic [31:0] cctl, input int nb, input int m);
    run_max = 0;
    beats   = 0;
    n_eot   = 0;
    axi_write(hdc_pkg::CTL_DMA, cctl);
    dev_cmd(8'hA1, dcfg);
    while (n_eot == 0) @(posedge clk_in);
    settle(3);
    cmp(n_eot, 1);
    cmp(beats, nb);
    cmp(run_max, m);
    dev_read(8'h21);
    cmp(rd16, dcfg & 16'h0067);
    axi_write(hdc_pkg::CTL_DMA, 32'h0000_0000);
  endtask
  initial begin
    arst_n_in = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    {oc_dig, oc_ana, susp, req_act} = 4'b0111;
    pend = 8'h04;
    ena  = 8'h04;
    repeat (8) @(posedge clk_in);
    arst_n_in <= 1'b1;
    dev_read(8'h20);
    cmp(rd16, 16'h0028);
    dev_read(8'h21);
    cmp(rd16, 16'h0000);
    axi_read(8'h40, s, rr);
    cmp(rr, hdc_pkg::RESP_SLVERR);
    axi_write(8'h40, 32'h0000_0000);
    cmp(br, hdc_pkg::RESP_SLVERR);
    $display("test reset done");
    dev_cmd(8'hA0, 16'hFFFF);
    dev_read(8'h20);
    cmp(rd16, 16'h1CAF);
    dev_cmd(8'hA1, 16'hFFFF);
    dev_read(8'h21);
    cmp(rd16, 16'h0077);
    settle(10);
    cmp(intf.dma_req_pin, 1'b0);
    dev_cmd(8'hA1, 16'h0000);
    dev_cmd(8'hA0, 16'h0028);
    $display("test registers done");
    settle(3);
    cmp(intf.irq_pin, 1'b1);
    dev_cmd(8'hA0, 16'h0029);
    settle(3);
    cmp(intf.irq_pin, 1'b0);
    @(posedge clk_in);
    ena <= 8'h00;
    settle(3);
    cmp(intf.irq_pin, 1'b1);
    @(posedge clk_in);
    ena <= 8'h04;
    dev_cmd(8'hA0, 16'h002D);
    settle(3);
    cmp(intf.irq_pin, 1'b1);
    @(posedge clk_in);
    pend <= 8'h00;
    dev_cmd(8'hA0, 16'h002F);
    settle(3);
    hi = 0;
    @(posedge clk_in);
    pend <= 8'h04;
    repeat (6) begin
      @(negedge clk_in);
      if (intf.irq_pin === 1'b1) hi++;
    end
    cmp(hi, 1);
    $display("test irq done");
    for (int i = 1; i >= 0; i--) begin
      dev_cmd(8'hA0, i[0] ? 16'h1C28 : 16'h0028);
      settle(3);
      cmp(oc, i[0]);
      cmp(stop_ok, !i[0]);
      cmp(pdn, i[0]);
    end
    $display("test pins done");
    axi_write(hdc_pkg::CTL_DDATA, 32'h0000_BEEF);
    for (int b = 0; b < 3; b++) begin
      dev_cmd(8'hA2, 16'h0010);
      run_dma(16'h0014 | 16'(b << 5) | (b[0] ? 16'h0003 : 16'h0000),
        b[0] ? 32'h0000_000B : 32'h0000_0009, 8, mx[b]);
      cmp(list_sel, b[0]);
      if (b[0]) cmp(last_wd, 16'hBEEF);
    end
    axi_read(hdc_pkg::CTL_DDATA, s, rr);
    cmp(s[15:0], 16'h5A3C);
    $display("test bursts done");
    dev_cmd(8'hA0, 16'h0080);
    req_act = 1'b0;
    run_dma(16'h0010, 32'h0003_0015, 3, 1);
    cmp(intf.dma_req_pin, 1'b1);
    axi_read(hdc_pkg::CTL_BEATS, s, rr);
    cmp(s[15:0], 16'h0003);
    $display("test end pin done");
    dev_cmd(8'hA0, 16'h0028);
    req_act = 1'b1;
    dev_cmd(8'hA2, 16'h0100);
    axi_write(hdc_pkg::CTL_DMA, 32'h0000_0009);
    beats = 0;
    dev_cmd(8'hA1, 16'h0014);
    while (beats == 0) @(posedge clk_in);
    dev_cmd(8'hA1, 16'h0000);
    settle(3);
    cmp(intf.dma_req_pin, 1'b0);
    dev_read(8'h22);
    cmp(rd16, 16'h0100);
    axi_write(hdc_pkg::CTL_DMA, 32'h0000_0000);
    $display("test stop done");
    give_verdict();
  end
endmodule
